// >>> src/prfh_handler.sv
// Set/get feature handler for the power state and range table features.
// Assumes commands come from same-clock queue logic and the data buffer is
// streamed one dword at a time, index 0 first, by a same-clock mover.
`timescale 1ns/10ps
// Contract
// RULE1: Selector 02h is the power state feature, parameters in dword 11.
// RULE2: Set power takes new state from dword 11 bits 4:0, ignores the rest.
// RULE3: Host requests only states below the advertised supported count.
// RULE4: Get power returns current state in completion dword 0.
// RULE5: Selector 03h is the optional range type feature.
// RULE6: Range count comes from dword 11; table moves through data buffer.
// RULE7: Table buffer is 4096 contiguous bytes; whole table is transferred.
// RULE8: Get range returns count in dword 0 and table in buffer.
// RULE9: Range count is dword 11 bits 5:0, zero based; rest reserved.
// RULE10: Table has 64 entries of 64 bytes; entry n at byte n*64.
// RULE11: Host keeps described ranges free of common blocks.
// RULE12: Entries beyond the described ranges are all zero bytes.
// RULE13: Entry byte 0 is the range type code.
// RULE14: Selector comes from dword 10 bits 7:0.
// RULE15: Controller reset returns non-persistent features to defaults.
// RULE16: Entry carries a 64-bit first block address.
// RULE17: Without the range feature, its commands end with invalid field.
module prfh_handler
  import prfh_pkg::*;
#(
  parameter bit RANGE_EN = 1'b1,
  parameter logic [4:0] PS_DEFAULT = PRFH_PS_DEFAULT
)
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic cmd_valid,
  input wire logic cmd_is_set,
  input wire logic [31:0] cmd_dw10,
  input wire logic [31:0] cmd_dw11,
  output logic cmd_ready_r,
  output logic cpl_valid_r,
  output logic [31:0] cpl_dw0_r,
  output logic [7:0] cpl_status_r,
  output logic [4:0] target_power_state,
  input wire logic [4:0] supported_power_state_count,
  input wire logic in_dw_valid,
  input wire logic [31:0] in_dw_data,
  output logic in_dw_ready_r,
  output logic out_dw_valid_r,
  output logic [31:0] out_dw_data_r,
  output logic [11:0] out_dw_byte_r,
  input wire logic out_dw_accept
);
  prfh_state_type state_r;
  logic [9:0] idx_r;
  logic [5:0] count_r;
  logic [5:0] new_count_r;
  logic [4:0] ps_r;
  logic [7:0] sel_r;
  logic set_r;
  logic [10:0] tx_cnt_r;
  logic [7:0] rd_type;
  logic [63:0] rd_first;
  logic wr_en;
  prfh_field_type wr_field;
  logic [31:0] wr_data;
  logic [31:0] rd_word;
  logic take;
  logic in_take;
  logic [7:0] cmd_sel;
  logic [5:0] idx_entry;
  logic [3:0] idx_word;

  assign take = cmd_valid && cmd_ready_r;
  assign in_take = in_dw_valid && in_dw_ready_r;
  assign cmd_sel = cmd_dw10[PRFH_SEL_MSB:0]; // [RULE14]
  assign idx_entry = idx_r[9:4]; // Entry n starts at dword n*16 [RULE10]
  assign idx_word = idx_r[3:0];
  assign target_power_state = ps_r;

  // Only state beyond supported count is host's problem; not checked here [RULE3]
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      ps_r <= PS_DEFAULT; // [RULE15]
    else if (take && cmd_is_set && cmd_sel == PRFH_SEL_POWER) // [RULE1]
      ps_r <= cmd_dw11[PRFH_PS_MSB:0]; // [RULE2]
  end

  // Stored count is persistent across power states, yet reset leaves it defined
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      count_r <= PRFH_COUNT_DEFAULT;
    else if (state_r == PRFH_SET_RX && in_take && idx_r == PRFH_LAST_DWORD)
      count_r <= new_count_r; // [RULE9]
  end

  // Store write: described entries keep type and first block, others cleared
  always_comb
  begin
    wr_en = state_r == PRFH_SET_RX && in_take;
    wr_field = PRFH_FLD_TYPE;
    if (idx_word == PRFH_DW_FIRST_LO)
      wr_field = PRFH_FLD_FIRST_LO;
    else if (idx_word == PRFH_DW_FIRST_HI)
      wr_field = PRFH_FLD_FIRST_HI;
    else if (idx_word != PRFH_DW_TYPE)
      wr_en = 1'b0;
    wr_data = (idx_entry <= new_count_r) ? in_dw_data : 32'h0; // [RULE12]
    if (wr_field == PRFH_FLD_TYPE)
      wr_data = {24'h0, wr_data[7:0]}; // [RULE13]
  end

  // Read side: fields outside the kept set, and unused entries, read as zero
  always_comb
  begin
    rd_word = 32'h0;
    if (idx_entry <= count_r) // [RULE12]
    begin
      case (idx_word)
        PRFH_DW_TYPE: rd_word = {24'h0, rd_type}; // [RULE13]
        PRFH_DW_FIRST_LO: rd_word = rd_first[31:0]; // [RULE16]
        PRFH_DW_FIRST_HI: rd_word = rd_first[63:32]; // [RULE16]
        default: rd_word = 32'h0;
      endcase
    end
  end

  prfh_range_store #(
    .ENTRIES(PRFH_MAX_ENTRIES)
  ) u_store (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .wr_en(wr_en),
    .wr_entry(idx_entry),
    .wr_field(wr_field),
    .wr_data(wr_data),
    .rd_entry(idx_entry),
    .rd_type(rd_type),
    .rd_first(rd_first)
  );

  // Command sequencing and completion
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      state_r <= PRFH_IDLE;
      cmd_ready_r <= 1'b0;
      cpl_valid_r <= 1'b0;
      cpl_dw0_r <= 32'h0;
      cpl_status_r <= PRFH_ST_SUCCESS;
      in_dw_ready_r <= 1'b0;
      out_dw_valid_r <= 1'b0;
      out_dw_data_r <= 32'h0;
      out_dw_byte_r <= 12'h0;
      idx_r <= 10'h0;
      new_count_r <= PRFH_COUNT_DEFAULT;
      sel_r <= 8'h0;
      set_r <= 1'b0;
    end
    else
    begin
      cpl_valid_r <= 1'b0;
      case (state_r)
        PRFH_IDLE:
        begin
          cmd_ready_r <= 1'b1;
          idx_r <= 10'h0;
          if (take)
          begin
            cmd_ready_r <= 1'b0;
            sel_r <= cmd_sel;
            set_r <= cmd_is_set;
            new_count_r <= cmd_dw11[PRFH_CNT_MSB:0]; // [RULE6] [RULE9]
            if (cmd_sel == PRFH_SEL_RANGE && RANGE_EN) // [RULE5]
            begin
              state_r <= cmd_is_set ? PRFH_SET_RX : PRFH_GET_TX;
              in_dw_ready_r <= cmd_is_set;
            end
            else
              state_r <= PRFH_DONE;
          end
        end
        PRFH_SET_RX:
        begin
          if (in_take)
          begin
            idx_r <= idx_r + 10'h1;
            if (idx_r == PRFH_LAST_DWORD) // Whole 4 KiB table consumed [RULE7]
            begin
              in_dw_ready_r <= 1'b0;
              state_r <= PRFH_DONE;
            end
          end
        end
        PRFH_GET_TX:
        begin
          // Bubble after each accept keeps the read path a single mux stage
          if (!out_dw_valid_r)
          begin
            out_dw_valid_r <= 1'b1;
            out_dw_data_r <= rd_word; // [RULE8]
            out_dw_byte_r <= {idx_r, 2'b00}; // [RULE10]
          end
          else if (out_dw_accept)
          begin
            out_dw_valid_r <= 1'b0;
            idx_r <= idx_r + 10'h1;
            if (idx_r == PRFH_LAST_DWORD) // [RULE7]
              state_r <= PRFH_DONE;
          end
        end
        PRFH_DONE:
        begin
          cpl_valid_r <= 1'b1;
          cpl_status_r <= PRFH_ST_SUCCESS;
          cpl_dw0_r <= 32'h0;
          state_r <= PRFH_IDLE;
          if (sel_r == PRFH_SEL_POWER && !set_r)
            cpl_dw0_r <= {27'h0, ps_r}; // [RULE4]
          else if (sel_r == PRFH_SEL_RANGE && RANGE_EN && !set_r)
            cpl_dw0_r <= {26'h0, count_r}; // [RULE8]
          else if (sel_r != PRFH_SEL_POWER && sel_r != PRFH_SEL_RANGE)
            cpl_status_r <= PRFH_ST_INVALID_FIELD;
          else if (sel_r == PRFH_SEL_RANGE && !RANGE_EN)
            cpl_status_r <= PRFH_ST_INVALID_FIELD; // [RULE17]
        end
        default: state_r <= PRFH_IDLE;
      endcase
    end
  end

  // Helper for assertions: dwords handed out in the current get
  always_ff @(posedge ref_clk)
  begin
    if (!resetn || state_r == PRFH_IDLE)
      tx_cnt_r <= 11'h0;
    else if (out_dw_valid_r && out_dw_accept)
      tx_cnt_r <= tx_cnt_r + 11'h1;
  end

  a_ps_reset_value: assert property (@(posedge ref_clk) // [RULE15]
    $rose(resetn) |-> target_power_state == PS_DEFAULT)
    else $error("power state not default after reset");

  a_ps_set_field: assert property (@(posedge ref_clk) disable iff (!resetn) // [RULE2]
    take && cmd_is_set && cmd_dw10[7:0] == 8'h02
    |=> target_power_state == $past(cmd_dw11[4:0]))
    else $error("power state not taken from dword 11 bits 4:0");

  a_ps_get_dw0: assert property (@(posedge ref_clk) disable iff (!resetn) // [RULE4]
    take && !cmd_is_set && cmd_dw10[7:0] == 8'h02
    |-> ##2 cpl_valid_r && cpl_dw0_r == {27'h0, ps_r} && cpl_status_r == 8'h00)
    else $error("power get completion wrong");

  a_bad_sel_status: assert property (@(posedge ref_clk) disable iff (!resetn) // [RULE14]
    take && cmd_dw10[7:0] != 8'h02 && cmd_dw10[7:0] != 8'h03
    |-> ##2 cpl_valid_r && cpl_status_r == 8'h02)
    else $error("unsupported selector not refused");

  a_range_off_status: assert property (@(posedge ref_clk) disable iff (!resetn) // [RULE17]
    take && !RANGE_EN && cmd_dw10[7:0] == 8'h03
    |-> ##2 cpl_valid_r && cpl_status_r == 8'h02)
    else $error("absent range feature not refused");

  a_range_get_dw0: assert property (@(posedge ref_clk) disable iff (!resetn) // [RULE8]
    cpl_valid_r && sel_r == 8'h03 && !set_r && RANGE_EN
    |-> cpl_dw0_r == {26'h0, count_r} && tx_cnt_r == 11'd1024)
    else $error("range get lacks count or whole table");

  a_unused_zero: assert property (@(posedge ref_clk) disable iff (!resetn) // [RULE12]
    out_dw_valid_r && out_dw_byte_r[11:6] > count_r |-> out_dw_data_r == 32'h0)
    else $error("unused entry not zero");

  a_entry_offset: assert property (@(posedge ref_clk) disable iff (!resetn) // [RULE10]
    out_dw_valid_r && !$past(out_dw_valid_r) |-> out_dw_byte_r == {tx_cnt_r[9:0], 2'b00})
    else $error("dword byte offset does not follow entry layout");

  a_count_update: assert property (@(posedge ref_clk) disable iff (!resetn) // [RULE9]
    state_r == PRFH_SET_RX && in_take && idx_r == 10'h3ff
    |=> count_r == $past(new_count_r) ##1 cpl_valid_r && cpl_status_r == 8'h00)
    else $error("range count not stored at table end");

  a_rx_ready_scope: assert property (@(posedge ref_clk) disable iff (!resetn) // [RULE6]
    in_dw_ready_r |-> state_r == PRFH_SET_RX && !cmd_ready_r)
    else $error("buffer input ready outside a range set");
endmodule

// >>> src/prfh_pkg.sv
// Constants and types for the power and range feature handler.
// Assumes a 32-bit command dword view and a dword-wide data buffer port.
package prfh_pkg;
  localparam logic [7:0] PRFH_SEL_POWER = 8'h02;
  localparam logic [7:0] PRFH_SEL_RANGE = 8'h03;
  localparam int PRFH_SEL_MSB = 7;
  localparam int PRFH_PS_MSB = 4;
  localparam int PRFH_CNT_MSB = 5;
  localparam logic [4:0] PRFH_PS_DEFAULT = 5'h00;
  localparam logic [5:0] PRFH_COUNT_DEFAULT = 6'h00;
  localparam int PRFH_TABLE_BYTES = 4096;
  localparam int PRFH_ENTRY_BYTES = 64;
  localparam int PRFH_MAX_ENTRIES = 64;
  localparam int PRFH_TABLE_DWORDS = PRFH_TABLE_BYTES / 4;
  localparam logic [9:0] PRFH_LAST_DWORD = 10'(PRFH_TABLE_DWORDS - 1);
  localparam logic [3:0] PRFH_DW_TYPE = 4'h0;
  localparam logic [3:0] PRFH_DW_FIRST_LO = 4'h4;
  localparam logic [3:0] PRFH_DW_FIRST_HI = 4'h5;
  localparam logic [7:0] PRFH_ST_SUCCESS = 8'h00;
  localparam logic [7:0] PRFH_ST_INVALID_FIELD = 8'h02;
  localparam logic [7:0] PRFH_TYPE_RESERVED = 8'h00;
  localparam logic [7:0] PRFH_TYPE_FILESYSTEM = 8'h01;
  localparam logic [7:0] PRFH_TYPE_RAID = 8'h02;
  localparam logic [7:0] PRFH_TYPE_CACHE = 8'h03;
  localparam logic [7:0] PRFH_TYPE_SWAP = 8'h04;

  typedef enum logic [1:0] {
    PRFH_FLD_TYPE = 2'h0,
    PRFH_FLD_FIRST_LO = 2'h1,
    PRFH_FLD_FIRST_HI = 2'h2
  } prfh_field_type;

  typedef enum logic [3:0] {
    PRFH_IDLE = 4'h1,
    PRFH_SET_RX = 4'h2,
    PRFH_GET_TX = 4'h4,
    PRFH_DONE = 4'h8
  } prfh_state_type;
endpackage

// >>> src/prfh_range_store.sv
// Flip-flop storage for the range table: type byte and first block per entry.
// Assumes one writer per cycle; read is combinational by entry index.
`timescale 1ns/10ps
module prfh_range_store
  import prfh_pkg::*;
#(
  parameter int ENTRIES = 64
)
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic wr_en,
  input wire logic [5:0] wr_entry,
  input wire prfh_field_type wr_field,
  input wire logic [31:0] wr_data,
  input wire logic [5:0] rd_entry,
  output logic [7:0] rd_type,
  output logic [63:0] rd_first
);
  logic [7:0] type_r [ENTRIES];
  logic [63:0] first_r [ENTRIES];

  genvar g;
  generate
    for (g = 0; g < ENTRIES; g++)
    begin : g_entry
      always_ff @(posedge ref_clk)
      begin
        if (!resetn)
        begin
          type_r[g] <= PRFH_TYPE_RESERVED;
          first_r[g] <= 64'h0;
        end
        else if (wr_en && wr_entry == 6'(g))
        begin
          case (wr_field)
            PRFH_FLD_TYPE: type_r[g] <= wr_data[7:0];
            PRFH_FLD_FIRST_LO: first_r[g][31:0] <= wr_data;
            PRFH_FLD_FIRST_HI: first_r[g][63:32] <= wr_data;
            default: type_r[g] <= type_r[g];
          endcase
        end
      end
    end
  endgenerate

  assign rd_type = type_r[rd_entry];
  assign rd_first = first_r[rd_entry];
endmodule

// >>> verif/prfh_handler_tb.sv
// Bench for the feature handler: power state and range table commands.
// Assumes a single 250 MHz clock; the host model moves buffer dwords.
`timescale 1ns/10ps
module prfh_handler_tb;
  import prfh_pkg::*;
  logic ref_clk, resetn, cmd_valid, cmd_is_set, src_en, slow;
  logic in_dw_valid, out_dw_accept, cmd_ready_r, cpl_valid_r, in_dw_ready_r, out_dw_valid_r;
  logic [31:0] cmd_dw10, cmd_dw11, in_dw_data, cpl_dw0_r, out_dw_data_r;
  logic [7:0] cpl_status_r, nr_status;
  logic [4:0] target_power_state;
  logic [11:0] out_dw_byte_r;
  int num_errors, n_tests, cyc, take_cyc;

  prfh_handler dut_u (.ref_clk(ref_clk), .resetn(resetn), .cmd_valid(cmd_valid),
    .cmd_is_set(cmd_is_set), .cmd_dw10(cmd_dw10), .cmd_dw11(cmd_dw11),
    .cmd_ready_r(cmd_ready_r), .cpl_valid_r(cpl_valid_r), .cpl_dw0_r(cpl_dw0_r),
    .cpl_status_r(cpl_status_r), .target_power_state(target_power_state),
    .supported_power_state_count(5'h1f), .in_dw_valid(in_dw_valid),
    .in_dw_data(in_dw_data), .in_dw_ready_r(in_dw_ready_r),
    .out_dw_valid_r(out_dw_valid_r), .out_dw_data_r(out_dw_data_r),
    .out_dw_byte_r(out_dw_byte_r), .out_dw_accept(out_dw_accept));
  prfh_host_model host_u (.ref_clk(ref_clk), .src_en(src_en), .slow(slow),
    .in_dw_ready_r(in_dw_ready_r), .out_dw_valid_r(out_dw_valid_r),
    .out_dw_data_r(out_dw_data_r), .out_dw_byte_r(out_dw_byte_r),
    .in_dw_valid(in_dw_valid), .in_dw_data(in_dw_data), .out_dw_accept(out_dw_accept));
  // Second copy without the optional range feature; takes the same commands
  prfh_handler #(.RANGE_EN(1'b0)) dut_nr_u (.ref_clk(ref_clk), .resetn(resetn),
    .cmd_valid(cmd_valid), .cmd_is_set(cmd_is_set), .cmd_dw10(cmd_dw10), .cmd_dw11(cmd_dw11),
    .cmd_ready_r(), .cpl_valid_r(), .cpl_dw0_r(), .cpl_status_r(nr_status),
    .target_power_state(), .supported_power_state_count(5'h1f), .in_dw_valid(1'b0),
    .in_dw_data(32'h0), .in_dw_ready_r(), .out_dw_valid_r(), .out_dw_data_r(),
    .out_dw_byte_r(), .out_dw_accept(1'b0));

  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    cyc = cyc + 1;
    if (cyc > 40000)
    begin
      num_errors = num_errors + 1;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests = n_tests + 1;
    if (seen !== exp)
    begin
      num_errors = num_errors + 1;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic do_reset(input int n);
    resetn = 1'b0;
    repeat (n) @(posedge ref_clk);
    #1 resetn = 1'b1;
    @(posedge ref_clk);
    #1;
    chk(32'(target_power_state), 32'(PRFH_PS_DEFAULT));
    chk(32'(cmd_ready_r), 32'h1);
  endtask

  // Lat above zero: completion must land exactly lat cycles after the take
  task automatic run_cmd(input logic set, input logic [7:0] sel, input logic [31:0] dw11,
    input int lat);
    int n;
    cmd_valid = 1'b1;
    cmd_is_set = set;
    cmd_dw10 = {24'hffffff, sel};
    cmd_dw11 = dw11;
    n = 0;
    while (cmd_ready_r !== 1'b1 && n < 100)
    begin
      @(posedge ref_clk);
      #1 n = n + 1;
    end
    chk(32'(cmd_ready_r), 32'h1);
    @(posedge ref_clk);
    #1 take_cyc = cyc;
    cmd_valid = 1'b0;
    n = 0;
    while (cpl_valid_r !== 1'b1 && n < 9000)
    begin
      @(posedge ref_clk);
      #1 n = n + 1;
    end
    chk(32'(cpl_valid_r), 32'h1);
    // Seen just after its launch edge, one edge before it is sampled
    if (lat > 0)
      chk(32'(cyc - take_cyc + 1), 32'(lat));
  endtask

  task automatic t_power(input logic [4:0] ps);
    run_cmd(1'b1, PRFH_SEL_POWER, {27'h7ffffff, ps}, 2);
    chk(32'(target_power_state), 32'(ps));
    run_cmd(1'b0, PRFH_SEL_POWER, 32'hffffffe0, 2);
    chk(cpl_dw0_r, {27'h0, ps});
  endtask

  task automatic t_badsel();
    run_cmd(1'b1, 8'h04, 32'h0, 2);
    chk(32'(cpl_status_r), 32'(PRFH_ST_INVALID_FIELD));
    run_cmd(1'b0, 8'h00, 32'h0, 2);
    chk(32'(cpl_status_r), 32'(PRFH_ST_INVALID_FIELD));
  endtask

  task automatic t_range(input logic [5:0] cnt, input logic stl);
    logic [31:0] e;
    logic [31:0] w;
    slow = stl;
    src_en = 1'b1;
    run_cmd(1'b1, PRFH_SEL_RANGE, {26'h3ffffff, cnt}, 0);
    src_en = 1'b0;
    chk(32'(cpl_status_r), 32'(PRFH_ST_SUCCESS));
    chk(32'(nr_status), 32'(PRFH_ST_INVALID_FIELD));
    for (int i = 0; i < 1024; i++)
      host_u.rd_mem[i] = 32'hx;
    run_cmd(1'b0, PRFH_SEL_RANGE, 32'h0, 0);
    chk(cpl_dw0_r, {26'h0, cnt});
    chk(32'(nr_status), 32'(PRFH_ST_INVALID_FIELD));
    for (int i = 0; i < 1024; i++)
    begin
      e = 32'h0;
      w = host_u.src_word(i);
      if (i / 16 <= int'(cnt) && (i % 16 == 4 || i % 16 == 5))
        e = host_u.src_word(i);
      if (i / 16 <= int'(cnt) && i % 16 == 0)
        e = {24'h0, w[7:0]};
      chk(host_u.rd_mem[i], e);
    end
    slow = 1'b0;
  endtask

  initial
  begin
    ref_clk = 1'b0;
    resetn = 1'b0;
    cmd_valid = 1'b0;
    cmd_is_set = 1'b0;
    cmd_dw10 = 32'h0;
    cmd_dw11 = 32'h0;
    src_en = 1'b0;
    slow = 1'b0;
    num_errors = 0;
    n_tests = 0;
    cyc = 0;
    do_reset(16);
    t_power(5'h05);
    t_power(5'h1f);
    t_power(5'h00);
    t_badsel();
    t_range(6'h02, 1'b1);
    t_range(6'h3f, 1'b0);
    t_range(6'h00, 1'b1);
    t_power(5'h07);
    // Reset in mid-run must drop the power state back to its default
    do_reset(2);
    give_verdict();
  end
endmodule

// >>> verif/prfh_host_model.sv
// Host buffer model: feeds the set-range table, collects the get-range table.
// Assumes src_en and slow change just after rising edges of ref_clk.
`timescale 1ns/10ps
module prfh_host_model
(
  input wire logic ref_clk,
  input wire logic src_en,
  input wire logic slow,
  input wire logic in_dw_ready_r,
  input wire logic out_dw_valid_r,
  input wire logic [31:0] out_dw_data_r,
  input wire logic [11:0] out_dw_byte_r,
  output logic in_dw_valid,
  output logic [31:0] in_dw_data,
  output logic out_dw_accept
);
  logic [31:0] rd_mem [1024];
  logic tk;
  int src_i = 0;
  int cyc = 0;
  function automatic logic [31:0] src_word(input int i);
    // Junk above the type byte must be dropped
    if (i % 16 == 0)
    begin
      return {24'hffffff, 8'(i / 16 % 5)};
    end
    return {12'habc, 10'(i), 10'(~i)};
  endfunction
  initial
  begin
    in_dw_valid = 1'b0;
    in_dw_data = 32'h0;
    out_dw_accept = 1'b0;
  end
  always @(posedge ref_clk)
  begin
    tk = in_dw_valid && in_dw_ready_r;
    if (tk)
    begin
      src_i = src_i + 1;
    end
    if (out_dw_valid_r && out_dw_accept)
    begin
      rd_mem[out_dw_byte_r[11:2]] = out_dw_data_r;
    end
    cyc = cyc + 1;
    #1;
    if (!src_en)
    begin
      src_i = 0;
    end
    out_dw_accept = !(slow && cyc % 3 == 1);
    // Held until taken; released data is inverted again on each idle cycle
    if (!in_dw_valid || tk)
    begin
      in_dw_valid = src_en && src_i < 1024 && !(slow && cyc % 3 == 0);
      in_dw_data = in_dw_valid ? src_word(src_i) : ~in_dw_data;
    end
  end
endmodule
